// ==== verilog/sbl_link.sv ====
/*
 serial block link adapter: host buffers, framed transmitter, framed receiver,
 interrupt request with vector. assumes a host that loads the buffers through
 the write port and acknowledges interrupts; the link line comes from another domain.
*/
`timescale 1ns/100ps
`default_nettype none
`include "sbl_defs.svh"
module sbl_link #(
   parameter logic [15:0] SYNC_WORD = `SBL_SYNC_DEF,
   parameter logic [15:0] CRC_POLY  = `SBL_CRC_POLY_DEF,
   parameter logic [7:0]  VECTOR    = `SBL_VECTOR_DEF,
   parameter int          BIT_CYC   = `SBL_BIT_CYCLES
) (
   // clock and control
   input  wire logic        clock,
   input  wire logic        rst,
   input  wire logic        clk_en,
   // host write into the control register path
   input  wire logic        host_wr,
   input  wire logic        host_sel_rx,
   input  wire logic [6:0]  host_addr,
   input  wire logic [15:0] host_wdata,
   input  wire logic        tx_start,
   // readback stream, two-entry buffered
   input  wire logic        rd_ready,
   output logic             rd_valid,
   output logic [15:0]      receive_readback_bus,
   // interrupt
   input  wire logic        int_ack,
   output logic             int_req,
   output logic [7:0]       vector_bus,
   output logic             vector_oe,
   // status
   output logic             tx_busy,
   output logic             rx_busy,
   output logic             crc_error,
   // link
   output logic             tx_line,
   input  wire logic        rx_line
);
   logic [15:0] tx_mem [0:127];
   logic [15:0] rx_mem [0:127];

   function automatic logic [15:0] crc_step(input logic [15:0] c, input logic b);
      crc_step = {c[14:0], 1'b0} ^ ((c[15] ^ b) ? CRC_POLY : 16'h0000);
   endfunction

   // device-select control register stage
   logic        sel_wr, sel_rx;
   logic [6:0]  sel_addr;
   logic [15:0] sel_data;
   logic        next_sel_wr;
   always_comb begin
      next_sel_wr = host_wr;
   end
   always_ff @(posedge clock) begin
      if (rst) begin
         sel_wr <= 1'b0; sel_rx <= 1'b0; sel_addr <= 7'h00; sel_data <= 16'h0000;
      end else if (clk_en) begin
         sel_wr   <= next_sel_wr;
         sel_rx   <= host_sel_rx;
         sel_addr <= host_addr;
         sel_data <= host_wdata;
      end
   end

   // bit timing; held at zero while idle so the first bit is a full period long
   sbl_pkg::sbl_tx_state_t tx_st, next_tx_st;
   logic [7:0] baud_cnt, next_baud_cnt;
   logic       baud_tick;
   always_comb begin
      baud_tick     = (baud_cnt == 8'(BIT_CYC - 1));
      next_baud_cnt = (baud_tick || tx_st == sbl_pkg::TX_IDLE) ? 8'h00 : baud_cnt + 8'h01;
   end
   always_ff @(posedge clock) begin
      if (rst) baud_cnt <= 8'h00;
      else if (clk_en) baud_cnt <= next_baud_cnt;
   end

   // transmitter
   logic [15:0] tx_sh, next_tx_sh, tx_crc, next_tx_crc;
   logic [4:0]  tx_bit, next_tx_bit;
   logic [6:0]  tx_idx, next_tx_idx, tx_cnt;
   logic        next_tx_line;
   always_comb begin
      next_tx_st = tx_st; next_tx_sh = tx_sh; next_tx_crc = tx_crc;
      next_tx_bit = tx_bit; next_tx_idx = tx_idx; next_tx_line = tx_line;
      case (tx_st)
         // software sequence of init and test blocks rides this engine
         sbl_pkg::TX_IDLE: begin
            next_tx_line = 1'b1;
            if (tx_start && tx_cnt != 7'h00) begin
               next_tx_st = sbl_pkg::TX_SYNC; next_tx_sh = SYNC_WORD;
               next_tx_bit = 5'd0; next_tx_idx = 7'd1;
            end
         end
         sbl_pkg::TX_SYNC: if (baud_tick) begin
            next_tx_line = tx_sh[15]; next_tx_sh = {tx_sh[14:0], 1'b0};
            next_tx_bit = tx_bit + 5'd1;
            if (tx_bit == 5'd15) begin
               next_tx_st = sbl_pkg::TX_NEXT; next_tx_crc = `SBL_CRC_INIT;
            end
         end
         sbl_pkg::TX_NEXT: begin
            next_tx_sh = tx_mem[tx_idx]; next_tx_bit = 5'd0; next_tx_st = sbl_pkg::TX_DATA;
         end
         sbl_pkg::TX_DATA: if (baud_tick) begin
            // parallel word shifted out msb first
            next_tx_line = tx_sh[15]; next_tx_sh = {tx_sh[14:0], 1'b0};
            next_tx_crc = crc_step(tx_crc, tx_sh[15]);
            next_tx_bit = tx_bit + 5'd1;
            if (tx_bit == 5'd15) begin
               if (tx_idx == tx_cnt) begin
                  next_tx_st = sbl_pkg::TX_CRC; next_tx_bit = 5'd0;
               end else begin
                  next_tx_idx = tx_idx + 7'd1; next_tx_st = sbl_pkg::TX_NEXT;
               end
            end
         end
         sbl_pkg::TX_CRC: if (baud_tick) begin
            next_tx_bit = tx_bit + 5'd1;
            // crc trails payload
            // the sixteenth crc bit keeps a full period before the line idles
            if (tx_bit == 5'd16) begin
               next_tx_st = sbl_pkg::TX_IDLE; next_tx_line = 1'b1;
            end else begin
               next_tx_line = tx_crc[15]; next_tx_crc = {tx_crc[14:0], 1'b0};
            end
         end
         default: next_tx_st = sbl_pkg::TX_IDLE;
      endcase
   end
   always_ff @(posedge clock) begin
      if (rst) begin
         tx_st <= sbl_pkg::TX_IDLE; tx_sh <= 16'h0000; tx_crc <= 16'h0000;
         tx_bit <= 5'd0; tx_idx <= 7'd0; tx_line <= 1'b1; tx_busy <= 1'b0;
      end else if (clk_en) begin
         tx_st <= next_tx_st; tx_sh <= next_tx_sh; tx_crc <= next_tx_crc;
         tx_bit <= next_tx_bit; tx_idx <= next_tx_idx; tx_line <= next_tx_line;
         tx_busy <= (next_tx_st != sbl_pkg::TX_IDLE);
      end
   end
   // count is low seven bits of entry zero
   assign tx_cnt = tx_mem[0][6:0];

   // receiver line synchroniser
   logic [2:0] rx_sync;
   logic       rx_bit_now;
   always_ff @(posedge clock) begin
      if (rst) begin
         rx_sync <= 3'b111; rx_bit_now <= 1'b1;
      end else if (clk_en) begin
         rx_sync <= {rx_sync[1:0], rx_line};
         if (rx_sync[1] == rx_sync[2]) rx_bit_now <= rx_sync[2];
      end
   end

   // receiver: samples mid-bit, edges resynchronise the phase
   sbl_pkg::sbl_rx_state_t rx_st, next_rx_st;
   logic [15:0] rx_sh, next_rx_sh, rx_crc, next_rx_crc;
   logic [4:0]  rx_bit, next_rx_bit;
   logic [6:0]  rx_idx, next_rx_idx, rx_cnt;
   logic [7:0]  rx_ph, next_rx_ph;
   logic        rx_prev, rx_smp, rx_wr, next_crc_error;
   logic        rx_done_pulse;
   always_comb begin
      next_rx_st = rx_st; next_rx_sh = rx_sh; next_rx_crc = rx_crc;
      next_rx_bit = rx_bit; next_rx_idx = rx_idx;
      // clear applied first, so a failing frame in the same cycle still sets
      next_crc_error = crc_error && !(sel_wr && sel_rx && sel_addr == 7'h00);
      rx_wr = 1'b0; rx_done_pulse = 1'b0;
      next_rx_ph = (rx_bit_now != rx_prev || rx_ph == 8'(BIT_CYC - 1)) ? 8'h00 : rx_ph + 8'h01;
      rx_smp = (rx_ph == 8'(BIT_CYC / 2));
      if (rx_smp) next_rx_sh = {rx_sh[14:0], rx_bit_now};
      case (rx_st)
         sbl_pkg::RX_HUNT: begin
            // sliding match on the sync word
            if (rx_smp && {rx_sh[14:0], rx_bit_now} == SYNC_WORD && rx_cnt != 7'h00) begin
               next_rx_st = sbl_pkg::RX_DATA; next_rx_bit = 5'd0;
               next_rx_idx = 7'd1; next_rx_crc = `SBL_CRC_INIT;
            end
         end
         sbl_pkg::RX_DATA: if (rx_smp) begin
            next_rx_crc = crc_step(rx_crc, rx_bit_now);
            next_rx_bit = rx_bit + 5'd1;
            if (rx_bit == 5'd15) begin
               // sixteen bits make one stored word
               rx_wr = 1'b1; next_rx_bit = 5'd0;
               if (rx_idx == rx_cnt) next_rx_st = sbl_pkg::RX_CRC;
               else next_rx_idx = rx_idx + 7'd1;
            end
         end
         sbl_pkg::RX_CRC: if (rx_smp) begin
            next_rx_bit = rx_bit + 5'd1;
            if (rx_bit == 5'd15) begin
               if ({rx_sh[14:0], rx_bit_now} != rx_crc) next_crc_error = 1'b1;
               next_rx_st = sbl_pkg::RX_DONE;
            end
         end
         sbl_pkg::RX_DONE: begin
            rx_done_pulse = 1'b1; next_rx_st = sbl_pkg::RX_HUNT;
         end
         default: next_rx_st = sbl_pkg::RX_HUNT;
      endcase
   end
   always_ff @(posedge clock) begin
      if (rst) begin
         rx_st <= sbl_pkg::RX_HUNT; rx_sh <= 16'h0000; rx_crc <= 16'h0000;
         rx_bit <= 5'd0; rx_idx <= 7'd0; rx_ph <= 8'h00; rx_prev <= 1'b1;
         crc_error <= 1'b0; rx_busy <= 1'b0;
      end else if (clk_en) begin
         rx_st <= next_rx_st; rx_sh <= next_rx_sh; rx_crc <= next_rx_crc;
         rx_bit <= next_rx_bit; rx_idx <= next_rx_idx; rx_ph <= next_rx_ph;
         rx_prev <= rx_bit_now; crc_error <= next_crc_error;
         // busy flag while a frame is in progress
         rx_busy <= (next_rx_st != sbl_pkg::RX_HUNT);
      end
   end
   assign rx_cnt = rx_mem[0][6:0];

   // buffer memories; stored payload written at rx_idx, checked crc recorded in flag
   always_ff @(posedge clock) begin
      if (clk_en) begin
         if (sel_wr && !sel_rx) tx_mem[sel_addr] <= sel_data;
         if (sel_wr && sel_rx) rx_mem[sel_addr] <= (sel_addr == 7'h00) ? {9'h000, sel_data[6:0]} : sel_data;
         else if (rx_wr) rx_mem[rx_idx] <= {rx_sh[14:0], rx_bit_now};
      end
   end

   // interrupt and vector
   logic rd_go, next_int_req;
   logic [6:0]  fill_idx;
   logic        in_ready;
   always_comb begin
      // request once whole response stored; set wins over acknowledge
      next_int_req = rx_done_pulse | (int_req & ~int_ack);
   end
   always_ff @(posedge clock) begin
      if (rst) begin
         int_req <= 1'b0; vector_bus <= 8'h00; vector_oe <= 1'b0; rd_go <= 1'b0;
      end else if (clk_en) begin
         int_req <= next_int_req;
         // vector onto bus on acknowledge; host scales it
         vector_oe  <= int_req & int_ack;
         vector_bus <= (int_req & int_ack) ? VECTOR : 8'h00;
         if (int_req & int_ack) rd_go <= 1'b1;
         else if (rd_go && fill_idx == rx_cnt && in_ready) rd_go <= 1'b0;
      end
   end

   // readback through two-entry skid buffer
   logic [15:0] b0, b1;
   logic        v0, v1;
   assign in_ready = !v1;
   always_ff @(posedge clock) begin
      if (rst) begin
         fill_idx <= 7'd1; v0 <= 1'b0; v1 <= 1'b0; b0 <= 16'h0000; b1 <= 16'h0000;
         rd_valid <= 1'b0; receive_readback_bus <= 16'h0000;
      end else if (clk_en) begin
         // stored words leave over the readback bus
         if (rd_valid && rd_ready) begin
            rd_valid <= 1'b0;
         end
         if (!rd_valid || rd_ready) begin
            if (v0) begin
               rd_valid <= 1'b1; receive_readback_bus <= b0;
               b0 <= b1; v0 <= v1; v1 <= 1'b0;
            end
         end
         if (rd_go && in_ready && !(v0 && !(!rd_valid || rd_ready) && v1)) begin
            if (!v0 || ((!rd_valid || rd_ready) && !v1)) begin
               if (v0 && !(!rd_valid || rd_ready)) begin b1 <= rx_mem[fill_idx]; v1 <= 1'b1; end
               else if (v0) begin b0 <= rx_mem[fill_idx]; v0 <= 1'b1; end
               else begin b0 <= rx_mem[fill_idx]; v0 <= 1'b1; end
            end else begin
               b1 <= rx_mem[fill_idx]; v1 <= 1'b1;
            end
            fill_idx <= (fill_idx == rx_cnt) ? 7'd1 : fill_idx + 7'd1;
         end
      end
   end
endmodule // sbl_link
`default_nettype wire

// ==== verilog/sbl_defs.svh ====
/*
 timing counts, widths and reset values for the serial block link adapter.
 assumes inclusion by bare name from the package and the design file.
*/
`ifndef SBL_DEFS_SVH
`define SBL_DEFS_SVH
`define SBL_CLK_HZ        125000000
`define SBL_BIT_RATE_HZ   998400
// longest period rounds down; 125e6/998400 = 125.2
`define SBL_BIT_CYCLES    (`SBL_CLK_HZ / `SBL_BIT_RATE_HZ)
`define SBL_WORD_W        16
`define SBL_CNT_W         7
`define SBL_BUF_DEPTH     128
`define SBL_BLOCK_WORDS   10
`define SBL_SYNC_DEF      16'hc3a5
`define SBL_CRC_POLY_DEF  16'h1021
`define SBL_CRC_INIT      16'hffff
`define SBL_VECTOR_DEF    8'h40
`define SBL_BIT_CNT_W     5
`endif

// ==== verilog/sbl_pkg.sv ====
/*
 types for the serial block link adapter.
 assumes sbl_defs.svh alongside.
*/
`include "sbl_defs.svh"
package sbl_pkg;
   typedef enum logic [2:0] {TX_IDLE, TX_SYNC, TX_DATA, TX_CRC, TX_NEXT} sbl_tx_state_t;
   typedef enum logic [1:0] {RX_HUNT, RX_DATA, RX_CRC, RX_DONE} sbl_rx_state_t;
endpackage

// ==== tb/sbl_link_properties.sv ====
/* port checks for sbl_link.
 assumes the bind at the foot attaches it to every sbl_link. */
`timescale 1ns/100ps
`default_nettype none
module sbl_link_properties #(
   parameter logic [7:0] VECTOR = 8'h40
) (
   // clock and host inputs
   input wire logic        clock,
   input wire logic        rst,
   input wire logic        clk_en,
   input wire logic        host_wr,
   input wire logic        tx_start,
   input wire logic        rd_ready,
   input wire logic        int_ack,
   // outputs
   input wire logic        rd_valid,
   input wire logic [15:0] receive_readback_bus,
   input wire logic        int_req,
   input wire logic [7:0]  vector_bus,
   input wire logic        vector_oe,
   input wire logic        tx_busy,
   input wire logic        crc_error,
   input wire logic        tx_line
);
   default clocking @(posedge clock); endclocking
   default disable iff (rst);
   vec_drive_a: assert property (clk_en && int_ack && int_req |=> vector_oe && vector_bus == VECTOR)
      else $error("vector missing after acknowledge");
   vec_cause_a: assert property ($rose(vector_oe) |-> $past(int_ack))
      else $error("vector driven without acknowledge");
   int_hold_a: assert property (int_req && !int_ack |=> int_req)
      else $error("interrupt dropped without acknowledge");
   busy_cause_a: assert property ($rose(tx_busy) |-> $past(tx_start))
      else $error("transmitter busy without start");
   line_idle_a: assert property (!tx_busy [*2] |-> tx_line)
      else $error("line not idle high");
   rd_hold_a: assert property (rd_valid && !rd_ready |=> rd_valid && $stable(receive_readback_bus))
      else $error("readback word lost under stall");
   crc_keep_a: assert property (crc_error && !host_wr && !$past(host_wr) && !$past(host_wr, 2)
      && !$past(host_wr, 3) |=> crc_error)
      else $error("crc error flag not sticky");
   freeze_hold_a: assert property (!clk_en |=> $stable(tx_line) && $stable(int_req))
      else $error("state moved while frozen");
   int_rise_c: cover property ($rose(int_req));
   crc_rise_c: cover property ($rose(crc_error));
   rd_stall_c: cover property (rd_valid && !rd_ready);
endmodule // sbl_link_properties
bind sbl_link sbl_link_properties #(.VECTOR(VECTOR)) u_sbl_link_properties (
   .clock(clock), .rst(rst), .clk_en(clk_en), .host_wr(host_wr), .tx_start(tx_start),
   .rd_ready(rd_ready), .int_ack(int_ack), .rd_valid(rd_valid),
   .receive_readback_bus(receive_readback_bus), .int_req(int_req), .vector_bus(vector_bus),
   .vector_oe(vector_oe), .tx_busy(tx_busy), .crc_error(crc_error), .tx_line(tx_line));
`default_nettype wire

// ==== tb/sbl_far_card.sv ====
/* far-end link card: one framed word train on rx_line per go pulse.
 assumes go only while idle; bad inverts the crc. */
`timescale 1ns/100ps
`default_nettype none
module sbl_far_card #(
   parameter int BIT_CYC = 8
) (
   // bench control
   input wire logic        clock,
   input wire logic        go,
   input wire logic        bad,
   input wire logic [6:0]  count,
   input wire logic [15:0] base,
   // link
   output logic            rx_line
);
   logic [15:0] crc;
   task automatic send(input logic [15:0] w, input logic upd);
      for (int b = 15; b >= 0; b--) begin
         #1 rx_line = w[b];
         if (upd) crc = {crc[14:0], 1'b0} ^ ((crc[15] ^ w[b]) ? 16'h1021 : 16'h0000);
         repeat (BIT_CYC) @(posedge clock);
      end
   endtask
   initial rx_line = 1'b1;
   // return path, idle high between frames
   always begin
      @(posedge clock iff go);
      crc = 16'hffff;
      send(16'hc3a5, 1'b0);
      for (int i = 1; i <= count; i++) send(base ^ 16'(i), 1'b1);
      send(bad ? ~crc : crc, 1'b0);
      #1 rx_line = 1'b1;
   end
endmodule // sbl_far_card
`default_nettype wire

// ==== tb/tb_sbl_link.sv ====
/* self-checking bench for sbl_link: far card sends frames, bench decodes tx_line.
 assumes BIT_CYC shortened to 8 and the default sync word and vector. */
`timescale 1ns/100ps
`default_nettype none
module tb_sbl_link;
   localparam int BC = 8;
   logic        clock = 1'b0, rst = 1'b1, clk_en = 1'b1, host_wr = 1'b0, host_sel_rx = 1'b0;
   logic [6:0]  host_addr = 7'h00, n7 = 7'h00;
   logic [15:0] host_wdata = 16'h0000, base = 16'h0000, rdata;
   logic        tx_start = 1'b0, rd_ready = 1'b0, int_ack = 1'b0, go = 1'b0, bad = 1'b0;
   logic        rd_valid, int_req, vector_oe, tx_busy, rx_busy, crc_error, tx_line, rx_line;
   logic [7:0]  vector_bus;
   logic [15:0] tw [0:127];
   int          num_errors = 0, cmp_count = 0, cyc = 0;
   sbl_link #(.BIT_CYC(BC)) u_sbl_link (.clock(clock), .rst(rst), .clk_en(clk_en),
      .host_wr(host_wr), .host_sel_rx(host_sel_rx), .host_addr(host_addr),
      .host_wdata(host_wdata), .tx_start(tx_start), .rd_ready(rd_ready), .rd_valid(rd_valid),
      .receive_readback_bus(rdata), .int_ack(int_ack), .int_req(int_req),
      .vector_bus(vector_bus), .vector_oe(vector_oe), .tx_busy(tx_busy), .rx_busy(rx_busy),
      .crc_error(crc_error), .tx_line(tx_line), .rx_line(rx_line));
   sbl_far_card #(.BIT_CYC(BC)) u_sbl_far_card (.clock(clock), .go(go), .bad(bad),
      .count(n7), .base(base), .rx_line(rx_line));
   always #4 clock = ~clock;
   task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         num_errors++;
         $display("BAD %s expected %h seen %h", what, exp, seen);
      end
   endtask
   function automatic logic [15:0] crc_step(input logic [15:0] c, input logic [15:0] w);
      for (int b = 15; b >= 0; b--) c = {c[14:0], 1'b0} ^ ((c[15] ^ w[b]) ? 16'h1021 : 16'h0);
      return c;
   endfunction
   task automatic finish_test();
      $display("comparisons %0d mismatches %0d", cmp_count, num_errors);
      if (num_errors == 0 && cmp_count > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   task automatic wr(input logic sel, input logic [6:0] a, input logic [15:0] d);
      @(negedge clock);
      {host_wr, host_sel_rx, host_addr, host_wdata} = {1'b1, sel, a, d};
      @(negedge clock);
      host_wr = 1'b0;
   endtask
   task automatic rx_test(input logic [6:0] n, input logic b);
      int k;
      logic busy_seen;
      busy_seen = 1'b0;
      wr(1'b1, 7'h00, {9'h000, n});
      repeat (3) @(negedge clock);
      {base, bad, n7, go} = {16'($urandom), b, n, 1'b1};
      @(negedge clock);
      go = 1'b0;
      for (k = 0; k < 20 * BC * (n + 3) && int_req !== 1'b1; k++) begin
         busy_seen = busy_seen | rx_busy;
         @(negedge clock);
      end
      check("rx_busy", {14'h0, busy_seen, rx_busy}, 16'h0002);
      check("crc_error", {15'h0, crc_error}, {15'h0, b});
      if (!b) check("int_req", {15'h0, int_req}, 16'h0001);
      if (int_req === 1'b1) begin
         int_ack = 1'b1;
         @(negedge clock);
         int_ack = 1'b0;
         if (!b) check("vector", {7'h0, vector_oe, vector_bus}, 16'h0140);
      end
      for (int i = 1; i <= n; i++) begin
         for (k = 0; k < 60; k++) begin
            rd_ready = 1'($urandom_range(0, 1));
            // taken at the coming rising edge; the word is settled now
            if (rd_valid === 1'b1 && rd_ready) break;
            @(negedge clock);
         end
         if (!b) check("rd_word", rdata, base ^ 16'(i));
         @(negedge clock);
      end
      rd_ready = 1'b0;
      if (!b) check("int_clear", {15'h0, int_req}, 16'h0000);
      if (b) begin
         wr(1'b1, 7'h00, {9'h000, n});
         repeat (4) @(negedge clock);
         check("crc_clear", {15'h0, crc_error}, 16'h0000);
      end
      $display("rx test done, count %0d, bad crc %0d", n, b);
   endtask
   task automatic tx_test(input logic [6:0] n);
      logic [15:0] c, w;
      int k;
      wr(1'b0, 7'h00, {9'h000, n});
      for (int i = 1; i <= n; i++) begin
         tw[i] = 16'($urandom);
         wr(1'b0, 7'(i), tw[i]);
      end
      repeat (3) @(negedge clock);
      tx_start = 1'b1;
      @(negedge clock);
      tx_start = 1'b0;
      for (k = 0; k < 50 && tx_busy !== 1'b1; k++) @(negedge clock);
      // first bit leaves one bit period after the start; sample mid bit
      repeat (BC + BC / 2 - 1) @(negedge clock);
      c = 16'hffff;
      for (int i = 0; i <= n + 1; i++) begin
         for (int b = 15; b >= 0; b--) begin
            w[b] = tx_line;
            repeat (BC) @(negedge clock);
         end
         check("tx_word", w, i == 0 ? 16'hc3a5 : (i > n ? c : tw[i]));
         if (i > 0 && i <= n) c = crc_step(c, tw[i]);
      end
      for (k = 0; k < 50 && tx_busy !== 1'b0; k++) @(negedge clock);
      check("tx_idle", {14'h0, tx_busy, tx_line}, 16'h0001);
      $display("tx test done, count %0d", n);
   endtask
   initial begin
      void'($urandom(32'h1249));
      repeat (3) @(negedge clock);
      rst = 1'b0;
      clk_en = 1'b0;
      repeat (3) @(negedge clock);
      clk_en = 1'b1;
      rx_test(7'd40, 1'b0);
      rx_test(7'd40, 1'b1);
      rx_test(7'($urandom_range(1, 20)), 1'b0);
      tx_test(7'd30);
      tx_test(7'd1);
      finish_test();
   end
   always @(posedge clock) begin
      cyc++;
      if (cyc == 60000) begin
         num_errors++;
         finish_test();
      end
   end
endmodule // tb_sbl_link
`default_nettype wire
